// *** logic/plbs_pkg.sv ***
// Shared constants and carriers for the pixel level, balance and shift block.
// Assumes one pixel clock domain and a simple strobed register port.
package plbs_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PIX_W = 12;
    localparam int BL_W = 10;
    localparam int RATIO_W = 8;
    localparam int RATIO_FRAC = 6;
    localparam int SHIFT_W = 3;
    localparam int SAT_CNT_W = 16;
    localparam int FIFO_DEPTH = 8;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] REG_BL_SEL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_BL_VAL = 8'h04;
    localparam logic [ADDR_W-1:0] REG_BR_SEL = 8'h08;
    localparam logic [ADDR_W-1:0] REG_BR_VAL = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_SHIFT = 8'h10;
    localparam logic [ADDR_W-1:0] REG_FORMAT = 8'h14;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h18;

    // Black level selector codes
    localparam logic [1:0] BL_SEL_ALL = 2'h0;
    localparam logic [1:0] BL_SEL_TAP1 = 2'h1;
    localparam logic [1:0] BL_SEL_TAP2 = 2'h2;

    // Colour codes, shared by balance selector and pixel tag
    localparam logic [1:0] COL_RED = 2'h0;
    localparam logic [1:0] COL_GREEN = 2'h1;
    localparam logic [1:0] COL_BLUE = 2'h2;

    localparam logic [SHIFT_W-1:0] SHIFT_MAX = 3'h4;
    localparam logic [RATIO_W-1:0] RATIO_ONE = 8'h40;
    localparam logic [BL_W-1:0] BL_RESET = 10'h000;
    localparam logic [PIX_W-1:0] PIX_ALL_ONES = 12'hFFF;
    localparam logic [PIX_W-1:0] PIX8_ALL_ONES = 12'h0FF;
    localparam int BL_TO_ADC_SHIFT = 2;
    localparam int PIX8_LSB = 4;

    typedef struct packed {
        logic half;
        logic [1:0] colour;
        logic [PIX_W-1:0] data;
    } plbs_pix_type;

endpackage

// *** logic/plbs_fifo.sv ***
// Small show-ahead FIFO with registered output word and registered ready.
// Assumes both sides on the same clock; reset is synchronous, active low.
`timescale 1ns/1ps
`default_nettype none
module plbs_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
        logic in_ready;
        logic out_valid;
        logic [WIDTH-1:0] out_data;
    } plbs_fifo_state_type;

    plbs_fifo_state_type st_r, st_nxt;
    logic push, pop;

    always_comb begin
        st_nxt = st_r;
        push = in_valid && st_r.in_ready;
        // Output word refills whenever it is empty or being taken
        pop = (st_r.cnt != '0) && (!st_r.out_valid || out_ready);
        if (push) begin
            st_nxt.mem[st_r.wp] = in_data;
            st_nxt.wp = (st_r.wp == PW'(DEPTH - 1)) ? '0 : st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.out_data = st_r.mem[st_r.rp];
            st_nxt.out_valid = 1'b1;
            st_nxt.rp = (st_r.rp == PW'(DEPTH - 1)) ? '0 : st_r.rp + 1'b1;
        end else if (out_ready) begin
            st_nxt.out_valid = 1'b0;
        end
        st_nxt.cnt = st_r.cnt + (PW+1)'(push) - (PW+1)'(pop);
        // Ready is conservative so it can come straight from a flop
        st_nxt.in_ready = (st_nxt.cnt < DEPTH_C);
        if (!rst_n) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge clock) begin
        st_r <= st_nxt;
    end

    assign in_ready = st_r.in_ready;
    assign out_valid = st_r.out_valid;
    assign out_data = st_r.out_data;
endmodule // plbs_fifo
`default_nettype wire

// *** logic/plbs_top.sv ***
// Pixel correction datapath: black level offset, colour balance, digital
// shift. Pixels arrive on the pixel clock from the ADC side logic; settings
// come over a strobed register port, read data one cycle after the strobe.
// Functional notes
// - Keep one global and two per-half black level settings.
// - Each black level setting is ten bits, range 0 to 1023.
// - Right half uses global plus first per-half setting.
// - Left half uses global plus second per-half setting.
// - In 8-bit depth, 64 steps of black level move output by one.
// - In 12-bit depth, 4 steps of black level move output by one.
// - Black level value write lands in the setting named by the selector.
// - Red, green, blue each scaled by own ratio; one means unchanged.
// - Ratio spans 0.00 to 3.98; below one lowers the reachable maximum.
// - Ratio value write lands only in the colour named by the selector.
// - 12-bit depth, no shift: all twelve bits pass unchanged.
// - 12-bit depth, shift n: bits 11-n to 0 then n zero bits.
// - Any set bit shifted out forces every output bit to one.
// - 8-bit depth outputs bits 11-n to 4-n, same saturation.
// - Shift setting zero disables, one to four shifts that far.
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module plbs_top
    import plbs_pkg::*;
#(
    parameter bit COLOUR_EN = 1'b1,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic pix_valid,
    output logic pix_ready,
    input wire logic [PIX_W-1:0] pix_data,
    input wire logic pix_half,
    input wire logic [1:0] pix_colour,
    output logic out_valid,
    input wire logic out_ready,
    output logic [PIX_W-1:0] out_pixel,
    output logic out_half,
    output logic [1:0] out_colour,
    output logic out_sat
);
    typedef struct packed {
        logic [BL_W-1:0] bl_all;
        logic [BL_W-1:0] bl_tap1;
        logic [BL_W-1:0] bl_tap2;
        logic [1:0] bl_sel;
        logic [1:0] br_sel;
        logic [2:0][RATIO_W-1:0] ratio;
        logic [SHIFT_W-1:0] shift;
        logic fmt12;
        logic out_valid;
        logic [PIX_W-1:0] out_pixel;
        logic out_half;
        logic [1:0] out_colour;
        logic out_sat;
        logic [SAT_CNT_W-1:0] sat_cnt;
        logic [DATA_W-1:0] rdata;
    } plbs_state_type;

    plbs_state_type st_r, st_nxt;

    // Clamp a wide intermediate to the twelve-bit pixel range
    function automatic logic [PIX_W-1:0] clip12(input logic [19:0] v);
        clip12 = (|v[19:PIX_W]) ? PIX_ALL_ONES : v[PIX_W-1:0];
    endfunction

    logic f_valid, f_ready;
    plbs_pix_type f_data, in_word;
    assign in_word = '{half: pix_half, colour: pix_colour, data: pix_data};

    plbs_fifo #(.WIDTH($bits(plbs_pix_type)), .DEPTH(DEPTH)) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(pix_valid),
        .in_ready(pix_ready),
        .in_data(in_word),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    logic load;
    logic [BL_W:0] bl_eff;
    logic [PIX_W-1:0] v_off, v_bal, v_sh;
    logic [RATIO_W-1:0] ratio_sel;
    logic [19:0] prod;
    logic [15:0] sh_wide;
    logic sat;
    logic wr_bl, wr_br, wr_shift;

    assign f_ready = !st_r.out_valid || out_ready;
    assign load = f_valid && f_ready;

    always_comb begin
        // Right half is tagged 0, left half 1
        bl_eff = {1'b0, st_r.bl_all}
            + (f_data.half ? {1'b0, st_r.bl_tap2}
                           : {1'b0, st_r.bl_tap1});
        // Quarter of the setting in ADC counts gives both depth scalings
        v_off = clip12(20'(f_data.data)
            + 20'(bl_eff >> BL_TO_ADC_SHIFT));
        ratio_sel = (f_data.colour > COL_BLUE) ? RATIO_ONE
                  : st_r.ratio[f_data.colour];
        prod = 20'(v_off) * 20'(ratio_sel);
        v_bal = COLOUR_EN ? clip12(prod >> RATIO_FRAC) : v_off;
        sh_wide = 16'(v_bal) << st_r.shift;
        sat = |sh_wide[15:PIX_W];
        if (st_r.fmt12) begin
            v_sh = sat ? PIX_ALL_ONES : sh_wide[PIX_W-1:0];
        end else begin
            v_sh = sat ? PIX8_ALL_ONES
                 : 12'(sh_wide[PIX_W-1:PIX8_LSB]);
        end
    end

    assign wr_bl = reg_wr && (reg_addr == REG_BL_VAL);
    assign wr_br = reg_wr && (reg_addr == REG_BR_VAL);
    assign wr_shift = reg_wr && (reg_addr == REG_SHIFT);

    always_comb begin
        st_nxt = st_r;
        // Register writes
        if (reg_wr && reg_addr == REG_BL_SEL
            && reg_wdata[1:0] <= BL_SEL_TAP2) begin
            st_nxt.bl_sel = reg_wdata[1:0];
        end
        if (wr_bl) begin
            case (st_r.bl_sel)
                BL_SEL_ALL: st_nxt.bl_all = reg_wdata[BL_W-1:0];
                BL_SEL_TAP1: st_nxt.bl_tap1 = reg_wdata[BL_W-1:0];
                BL_SEL_TAP2: st_nxt.bl_tap2 = reg_wdata[BL_W-1:0];
                default: st_nxt.bl_all = st_r.bl_all;
            endcase
        end
        if (reg_wr && reg_addr == REG_BR_SEL
            && reg_wdata[1:0] <= COL_BLUE) begin
            st_nxt.br_sel = reg_wdata[1:0];
        end
        if (wr_br && st_r.br_sel <= COL_BLUE) begin
            st_nxt.ratio[st_r.br_sel] = reg_wdata[RATIO_W-1:0];
        end
        // Out-of-range shift codes are ignored
        if (wr_shift && reg_wdata[SHIFT_W-1:0] <= SHIFT_MAX
            && reg_wdata[DATA_W-1:SHIFT_W] == '0) begin
            st_nxt.shift = reg_wdata[SHIFT_W-1:0];
        end
        if (reg_wr && reg_addr == REG_FORMAT) begin
            st_nxt.fmt12 = reg_wdata[0];
        end
        // Register reads, data valid the cycle after the strobe
        st_nxt.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                REG_BL_SEL: st_nxt.rdata = 32'(st_r.bl_sel);
                REG_BL_VAL: begin
                    case (st_r.bl_sel)
                        BL_SEL_TAP1: st_nxt.rdata = 32'(st_r.bl_tap1);
                        BL_SEL_TAP2: st_nxt.rdata = 32'(st_r.bl_tap2);
                        default: st_nxt.rdata = 32'(st_r.bl_all);
                    endcase
                end
                REG_BR_SEL: st_nxt.rdata = 32'(st_r.br_sel);
                REG_BR_VAL: st_nxt.rdata = 32'(st_r.ratio[st_r.br_sel]);
                REG_SHIFT: st_nxt.rdata = 32'(st_r.shift);
                REG_FORMAT: st_nxt.rdata = 32'(st_r.fmt12);
                REG_STATUS: st_nxt.rdata = 32'(st_r.sat_cnt);
                default: st_nxt.rdata = '0;
            endcase
        end
        // Output stage holds while the formatter stalls
        if (load) begin
            st_nxt.out_valid = 1'b1;
            st_nxt.out_pixel = v_sh;
            st_nxt.out_half = f_data.half;
            st_nxt.out_colour = f_data.colour;
            st_nxt.out_sat = sat;
            st_nxt.sat_cnt = st_r.sat_cnt + SAT_CNT_W'(sat);
        end else if (out_ready) begin
            st_nxt.out_valid = 1'b0;
        end
        if (!rst_n) begin
            st_nxt = '0;
            st_nxt.bl_all = BL_RESET;
            st_nxt.bl_tap1 = BL_RESET;
            st_nxt.bl_tap2 = BL_RESET;
            st_nxt.ratio = {3{RATIO_ONE}};
            st_nxt.fmt12 = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        st_r <= st_nxt;
    end

    assign reg_rdata = st_r.rdata;
    assign out_valid = st_r.out_valid;
    assign out_pixel = st_r.out_pixel;
    assign out_half = st_r.out_half;
    assign out_colour = st_r.out_colour;
    assign out_sat = st_r.out_sat;

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    logic plain_path;
    assign plain_path = (st_r.shift == '0)
        && (st_r.ratio == {3{RATIO_ONE}});

    sequence s_load_plain_zero(logic h);
        load && plain_path && f_data.data == '0 && f_data.half == h;
    endsequence

    a_bl_sel_write: assert property (
        wr_bl && st_r.bl_sel == BL_SEL_TAP2 |=>
            st_r.bl_tap2 == $past(reg_wdata[BL_W-1:0])
            && $stable(st_r.bl_all) && $stable(st_r.bl_tap1))
        else $error("black level write missed selected setting");

    a_bl_right_sum: assert property (
        s_load_plain_zero(1'b0) ##0 st_r.fmt12 |=>
            out_pixel == 12'(($past(st_r.bl_all) + 11'($past(st_r.bl_tap1)))
                             >> BL_TO_ADC_SHIFT))
        else $error("right half black level wrong");

    a_bl_left_sum: assert property (
        s_load_plain_zero(1'b1) ##0 st_r.fmt12 |=>
            out_pixel == 12'(($past(st_r.bl_all) + 11'($past(st_r.bl_tap2)))
                             >> BL_TO_ADC_SHIFT))
        else $error("left half black level wrong");

    a_bl_eight_bit: assert property (
        s_load_plain_zero(1'b0) ##0 !st_r.fmt12 |=>
            out_pixel == 12'(($past(st_r.bl_all) + 11'($past(st_r.bl_tap1)))
                             >> 6))
        else $error("8-bit black level scaling wrong");

    a_ratio_select: assert property (
        wr_br && st_r.br_sel == COL_GREEN |=>
            st_r.ratio[COL_GREEN] == $past(reg_wdata[RATIO_W-1:0])
            && $stable(st_r.ratio[COL_RED]) && $stable(st_r.ratio[COL_BLUE]))
        else $error("ratio write reached wrong colour");

    a_ratio_scale: assert property (
        load && st_r.shift == '0 && st_r.fmt12 && bl_eff == '0
        && f_data.colour <= COL_BLUE |=>
            out_pixel == clip12((20'($past(f_data.data))
                * 20'($past(ratio_sel))) >> RATIO_FRAC))
        else $error("balance scaling wrong");

    a_pass_twelve: assert property (
        load && plain_path && st_r.fmt12 && bl_eff == '0 |=>
            out_pixel == $past(f_data.data) && !out_sat)
        else $error("unshifted 12-bit pixel altered");

    a_shift_lsbs: assert property (
        load && st_r.fmt12 && st_r.shift != '0 && !sat |=>
            (out_pixel & ((12'h001 << $past(st_r.shift)) - 12'h001)) == '0)
        else $error("shifted pixel low bits not zero");

    a_saturate: assert property (
        out_valid && out_sat |->
            out_pixel == (st_r.fmt12 ? PIX_ALL_ONES : PIX8_ALL_ONES)
            || $changed(st_r.fmt12))
        else $error("saturated pixel not all ones");

    a_shift_code: assert property (
        wr_shift && reg_wdata[SHIFT_W-1:0] > SHIFT_MAX |=> $stable(st_r.shift))
        else $error("illegal shift code accepted");

    a_out_hold: assert property (
        out_valid && !out_ready |=> out_valid && $stable(out_pixel))
        else $error("output dropped under stall");
endmodule // plbs_top
`default_nettype wire

// *** verif/plbs_far_end.sv ***
// Far side model: ADC pixel source and pixel formatter sink.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module plbs_far_end
    import plbs_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic stall,
    output logic pix_valid,
    input wire logic pix_ready,
    output logic [PIX_W-1:0] pix_data,
    output logic pix_half,
    output logic [1:0] pix_colour,
    input wire logic out_valid,
    output logic out_ready,
    input wire logic [PIX_W-1:0] out_pixel,
    input wire logic out_half,
    input wire logic [1:0] out_colour,
    input wire logic out_sat
);
    logic [15:0] got[$];

    initial begin
        pix_valid = 1'b0;
        pix_data = 12'h000;
        pix_half = 1'b0;
        pix_colour = 2'h0;
        out_ready = 1'b0;
    end

    // Caller repeats the same word until taken, so it holds unchanged
    // Ready is sampled mid-cycle, away from the edge that updates it
    task automatic try_send(input logic h, input logic [1:0] c,
        input logic [PIX_W-1:0] d, output bit took);
        pix_valid <= 1'b1;
        pix_half <= h;
        pix_colour <= c;
        pix_data <= d;
        @(negedge clock);
        took = (pix_ready === 1'b1);
        @(posedge clock);
    endtask

    // Released data lines must not keep showing the last pixel
    task automatic idle();
        pix_valid <= 1'b0;
        pix_data <= ~pix_data;
    endtask

    always @(posedge clock) begin
        out_ready <= ~stall;
        if (rst_n && out_valid && out_ready) begin
            got.push_back({out_sat, out_half, out_colour, out_pixel});
        end
    end
endmodule // plbs_far_end
`default_nettype wire

// *** verif/plbs_top_tb.sv ***
// Self-checking bench for the pixel level, balance and shift block.
// Assumes the far side model file is compiled before this one.
`timescale 1ns/1ps
`default_nettype none
module plbs_top_tb
    import plbs_pkg::*;
;
    logic clock, rst_n, reg_wr, reg_rd, stall;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic pix_valid, pix_ready, pix_half, out_valid, out_ready;
    logic out_half, out_sat;
    logic [PIX_W-1:0] pix_data, out_pixel;
    logic [1:0] pix_colour, out_colour;
    logic [9:0] bl[3];
    logic [7:0] rt[4];
    int sh, fails, n_compared, sat_n;
    bit f12;

    plbs_top #(.DEPTH(FIFO_DEPTH)) u_plbs_top (.clock(clock), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_valid(pix_valid),
        .pix_ready(pix_ready), .pix_data(pix_data), .pix_half(pix_half),
        .pix_colour(pix_colour), .out_valid(out_valid),
        .out_ready(out_ready), .out_pixel(out_pixel), .out_half(out_half),
        .out_colour(out_colour), .out_sat(out_sat));
    plbs_far_end u_plbs_far_end (.clock(clock), .rst_n(rst_n),
        .stall(stall), .pix_valid(pix_valid), .pix_ready(pix_ready),
        .pix_data(pix_data), .pix_half(pix_half), .pix_colour(pix_colour),
        .out_valid(out_valid), .out_ready(out_ready),
        .out_pixel(out_pixel), .out_half(out_half),
        .out_colour(out_colour), .out_sat(out_sat));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic results();
        if (fails == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask

    // Selector and value in adjacent cycles, the tightest legal spacing
    task automatic set(input logic [ADDR_W-1:0] sa, input logic [31:0] s,
        input logic [31:0] v);
        reg_addr <= sa;
        reg_wdata <= s;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_addr <= sa + 8'h04;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        chk("reg_rdata", e, reg_rdata);
        @(posedge clock);
    endtask

    function automatic logic [15:0] model(input logic h,
        input logic [1:0] c, input logic [11:0] p);
        logic [12:0] v1;
        logic [19:0] v2;
        logic [23:0] s;
        logic sat;
        v1 = 13'(p) + 13'((11'(bl[0]) + 11'(h ? bl[2] : bl[1])) >> 2);
        if (v1 > 13'h0FFF) v1 = 13'h0FFF;
        v2 = (20'(v1) * 20'(rt[c])) >> RATIO_FRAC;
        if (v2 > 20'h00FFF) v2 = 20'h00FFF;
        s = 24'(v2) << sh;
        sat = |s[23:12];
        if (f12) return {sat, h, c, sat ? PIX_ALL_ONES : s[11:0]};
        return {sat, h, c, sat ? PIX8_ALL_ONES : {4'h0, s[11:4]}};
    endfunction

    task automatic pix(input logic h, input logic [1:0] c,
        input logic [11:0] p);
        bit took;
        int k;
        logic [15:0] e;
        e = model(h, c, p);
        took = 1'b0;
        while (!took) u_plbs_far_end.try_send(h, c, p, took);
        u_plbs_far_end.idle();
        k = 0;
        while (u_plbs_far_end.got.size() == 0 && k < 20) begin
            @(negedge clock);
            k++;
        end
        if (k == 20) chk("out_word", e, 32'hX);
        else chk("out_word", e, u_plbs_far_end.got.pop_front());
        sat_n += e[15];
        @(posedge clock);
    endtask

    task automatic t_reset();
        rd(REG_BL_VAL, 32'h0000_0000);
        rd(REG_BR_VAL, 32'h0000_0040);
        rd(REG_SHIFT, 32'h0000_0000);
        rd(REG_FORMAT, 32'h0000_0001);
        rd(REG_STATUS, 32'h0000_0000);
        rd(8'h1C, 32'h0000_0000);
    endtask

    task automatic t_fifo();
        bit took;
        int i, k;
        i = 0;
        repeat (24) begin
            u_plbs_far_end.try_send(1'b0, 2'h3, 12'(i), took);
            if (took) i++;
        end
        u_plbs_far_end.idle();
        @(negedge clock);
        chk("pix_ready", 32'h0, 32'(pix_ready));
        chk("fill_count", 32'(FIFO_DEPTH + 2), 32'(i));
        @(posedge clock);
        stall <= 1'b0;
        k = 0;
        while (u_plbs_far_end.got.size() < i && k < 100) begin
            @(negedge clock);
            k++;
        end
        for (k = 0; k < i; k++) begin
            chk("drain_word", {18'h0, 2'h3, 12'(k)},
                u_plbs_far_end.got.pop_front());
        end
        @(posedge clock);
    endtask

    task automatic bl_set(input logic [1:0] s, input logic [9:0] v);
        set(REG_BL_SEL, 32'(s), 32'(v));
        bl[s] = v;
    endtask

    task automatic fmt(input bit f);
        wr(REG_FORMAT, 32'(f));
        f12 = f;
    endtask

    task automatic t_black();
        bl_set(BL_SEL_ALL, 10'h003);
        bl_set(BL_SEL_TAP1, 10'h005);
        bl_set(BL_SEL_TAP2, 10'h3FC);
        rd(REG_BL_VAL, 32'h0000_03FC);
        pix(1'b0, 2'h3, 12'h000);
        pix(1'b1, 2'h3, 12'h000);
        pix(1'b0, 2'h3, 12'h064);
        pix(1'b1, 2'h3, 12'h064);
        bl_set(BL_SEL_TAP2, 10'h000);
        bl_set(BL_SEL_ALL, 10'h007);
        pix(1'b0, 2'h3, 12'h064);
        fmt(1'b0);
        bl_set(BL_SEL_ALL, 10'h043);
        pix(1'b0, 2'h3, 12'h000);
        pix(1'b0, 2'h3, 12'h400);
        bl_set(BL_SEL_ALL, 10'h083);
        pix(1'b0, 2'h3, 12'h400);
        fmt(1'b1);
        bl_set(BL_SEL_ALL, 10'h000);
        bl_set(BL_SEL_TAP1, 10'h000);
    endtask

    task automatic t_balance();
        logic [7:0] r[3];
        r = '{8'h80, 8'h20, 8'hFF};
        for (int c = 0; c < 3; c++) begin
            set(REG_BR_SEL, 32'(c), 32'(r[c]));
            rt[c] = r[c];
        end
        rd(REG_BR_VAL, 32'h0000_00FF);
        for (int c = 0; c < 4; c++) pix(1'b0, 2'(c), 12'h300);
        pix(1'b1, COL_GREEN, 12'hFFF);
    endtask

    task automatic t_shift();
        for (int n = 0; n <= 4; n++) begin
            wr(REG_SHIFT, 32'(n));
            sh = n;
            for (int f = 1; f >= 0; f--) begin
                fmt(f[0]);
                pix(1'b1, 2'h3, 12'h07F);
                pix(1'b0, 2'h3, 12'(13'h1000 >> n));
            end
        end
        wr(REG_SHIFT, 32'h0000_0005);
        rd(REG_SHIFT, 32'h0000_0004);
        rd(REG_STATUS, 32'(sat_n));
    endtask

    initial begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        stall = 1'b1;
        bl = '{default: 10'h000};
        rt = '{default: RATIO_ONE};
        sh = 0;
        f12 = 1'b1;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_reset();
        t_fifo();
        t_black();
        t_balance();
        t_shift();
        results();
    end

    // Whole run needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        results();
    end
endmodule // plbs_top_tb
`default_nettype wire
